// ===== core/rct_pkg.sv
// constants, register map and types shared by the reset cause tracker
package rct_pkg;

    // ==================================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [31:0] RCT_ADDR_STATUS     = 32'hFFFF_0230;
    localparam logic [31:0] RCT_ADDR_CLEAR      = 32'hFFFF_0234;
    localparam logic [31:0] RCT_ADDR_IRQ_STATUS = 32'hFFFF_0238;
    localparam logic [31:0] RCT_ADDR_IRQ_CLEAR  = 32'hFFFF_023C;
    localparam logic [31:0] RCT_ADDR_IRQ_ENABLE = 32'hFFFF_0240;

    // ==================================================================
    // field layout of the cause bits
    localparam int RCT_REG_W   = 8;
    localparam int RCT_CAUSE_W = 4;
    localparam int RCT_BIT_POR = 0;
    localparam int RCT_BIT_WDT = 1;
    localparam int RCT_BIT_SW  = 2;
    localparam int RCT_BIT_EXT = 3;
    localparam int RCT_PAD_W   = 32 - RCT_CAUSE_W;

    localparam logic [RCT_CAUSE_W-1:0] RCT_CAUSE_NONE = 4'h0;
    localparam logic [RCT_PAD_W-1:0]   RCT_PAD_ZERO   = 28'h000_0000;
    localparam logic [31:0]            RCT_DATA_ZERO  = 32'h0000_0000;

    // ==================================================================
    // bus answers
    localparam logic [1:0] RCT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RCT_RESP_SLVERR = 2'h2;

    // ==================================================================
    // pin conditioning: two active-low pins, power-on detector and reset pin
    localparam int             RCT_PIN_W    = 2;
    localparam int             RCT_PIN_POR  = 0;
    localparam int             RCT_PIN_EXT  = 1;
    localparam logic [1:0]     RCT_PIN_IDLE = 2'h3;
    localparam logic [1:0]     RCT_PIN_NONE = 2'h0;

    // ==================================================================
    // timing
    localparam int RCT_CLK_MHZ = 125;
    localparam int RCT_HOLD_NS = 1000;
    localparam int RCT_HOLD_CYC_I = (RCT_HOLD_NS * RCT_CLK_MHZ + 999) / 1000;
    localparam int RCT_CNT_W = 8;
    localparam logic [RCT_CNT_W-1:0] RCT_HOLD_CYC = RCT_CNT_W'(RCT_HOLD_CYC_I);
    localparam logic [RCT_CNT_W-1:0] RCT_CNT_ZERO = 8'h00;
    localparam logic [RCT_CNT_W-1:0] RCT_CNT_ONE  = 8'h01;

    // ==================================================================
    // sequencer states
    typedef enum logic [1:0] {
        RCT_IDLE,
        RCT_HOLD,
        RCT_BOOT
    } rct_state_e;

endpackage

// ===== core/rct_pin_if.sv
// carrier between the pin conditioner and the tracker core
interface rct_pin_if;
    import rct_pkg::*;

    logic [RCT_PIN_W-1:0] raw_n;
    logic [RCT_PIN_W-1:0] active;
    logic [RCT_PIN_W-1:0] assert_p;

    modport filt (input raw_n, output active, output assert_p);
    modport user (output raw_n, input active, input assert_p);
endinterface

// ===== core/rct_pin_filter.sv
// three-flop synchroniser with agreement filter for the active-low reset pins
module rct_pin_filter
    import rct_pkg::*;
(
    // clock and reset
    input  wire logic   aclk,
    input  wire logic   aresetn,
    // pins and conditioned levels
    rct_pin_if.filt     pins
);
    import rct_pkg::*;

    logic [RCT_PIN_W-1:0] meta_r;
    logic [RCT_PIN_W-1:0] s2_r;
    logic [RCT_PIN_W-1:0] s3_r;
    logic [RCT_PIN_W-1:0] active_r;
    logic [RCT_PIN_W-1:0] active_nxt;
    logic [RCT_PIN_W-1:0] pulse_r;

    // ==================================================================
    // synchroniser chain, meta_r feeds s2_r only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= RCT_PIN_IDLE;
            s2_r   <= RCT_PIN_IDLE;
            s3_r   <= RCT_PIN_IDLE;
        end else begin
            meta_r <= pins.raw_n;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // ==================================================================
    // a change counts only once two stages agree, which rejects single glitches
    always_comb begin
        active_nxt = active_r;
        for (int i = 0; i < RCT_PIN_W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                active_nxt[i] = ~s3_r[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_r <= RCT_PIN_NONE;
            pulse_r  <= RCT_PIN_NONE;
        end else begin
            active_r <= active_nxt;
            pulse_r  <= active_nxt & ~active_r;
        end
    end

    assign pins.active   = active_r;
    assign pins.assert_p = pulse_r;

endmodule

// ===== core/rct_top.sv
// reset cause tracker: cause register, reset sequencing and axi4-lite slave
//
// Operation
// - four reset sources are told apart; the last cause stays readable.
// - writing one to status bit 2 requests and performs a software reset.
// - clear register at 0xFFFF0234; each written one clears that status bit.
// - status bits 7 to 4 always read as zero.
// - an external pin reset sets status bit 3.
// - a watchdog timeout sets status bit 1.
// - a power-on reset sets status bit 0.
// - clear write leaving software bit set triggers another software reset.
// - every reset resets pins, peripherals, registers and boots kernel; status kept.
// - only power-on resets the watchdog; other resets keep ram valid.
// - status register at 0xFFFF0230; its value follows the reset source.
//
// Chosen here: the AXI4-Lite interface to the registers.
module rct_top
    import rct_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic [31:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // reset sources
    input  wire logic                   por_n,
    input  wire logic                   ext_rst_n,
    input  wire logic                   wdt_timeout,
    // reset effects
    output logic                        sys_rst_n,
    output logic                        wdt_rst_n,
    output logic                        kernel_start,
    output logic                        ram_valid,
    // interrupt
    output logic                        irq
);
    import rct_pkg::*;

    // ==================================================================
    // declarations
    rct_pin_if                          pin_bus ();

    rct_state_e                         state_r;
    rct_state_e                         state_nxt;
    logic [RCT_CNT_W-1:0]               cnt_r;
    logic                               por_kind_r;
    logic                               sys_rst_n_r;
    logic                               wdt_rst_n_r;
    logic                               kernel_start_r;
    logic                               ram_valid_r;

    logic [RCT_CAUSE_W-1:0]             status_r;
    logic [RCT_CAUSE_W-1:0]             status_nxt;
    logic [RCT_CAUSE_W-1:0]             irq_status_r;
    logic [RCT_CAUSE_W-1:0]             irq_status_nxt;
    logic [RCT_CAUSE_W-1:0]             irq_enable_r;
    logic [RCT_CAUSE_W-1:0]             trig;
    logic                               wdt_prev_r;

    logic                               aw_hold_r;
    logic [31:0]                        aw_addr_r;
    logic                               w_hold_r;
    logic [31:0]                        w_data_r;
    logic [3:0]                         w_strb_r;
    logic                               bvalid_r;
    logic [1:0]                         bresp_r;
    logic                               rvalid_r;
    logic [31:0]                        rdata_r;
    logic [1:0]                         rresp_r;

    logic                               wr_fire;
    logic                               wr_lane0;
    logic [RCT_CAUSE_W-1:0]             wr_bits;
    logic                               wr_status;
    logic                               wr_clear;
    logic                               wr_irq_clear;
    logic                               wr_irq_enable;
    logic                               sw_req;

    // ==================================================================
    // address decode, shared by the read and write paths
    function automatic logic rct_mapped(input logic [31:0] addr);
        rct_mapped = (addr == RCT_ADDR_STATUS) || (addr == RCT_ADDR_CLEAR) ||
                     (addr == RCT_ADDR_IRQ_STATUS) || (addr == RCT_ADDR_IRQ_CLEAR) ||
                     (addr == RCT_ADDR_IRQ_ENABLE);
    endfunction

    function automatic logic [31:0] rct_word(input logic [RCT_CAUSE_W-1:0] bits);
        rct_word = {RCT_PAD_ZERO, bits};
    endfunction

    // ==================================================================
    // pin conditioning
    assign pin_bus.raw_n[RCT_PIN_POR] = por_n;
    assign pin_bus.raw_n[RCT_PIN_EXT] = ext_rst_n;

    rct_pin_filter u_pin_filter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pin_bus.filt)
    );

    // watchdog shares this clock, so only its rising edge is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_prev_r <= 1'b0;
        end else begin
            wdt_prev_r <= wdt_timeout;
        end
    end

    // ==================================================================
    // write decode
    assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_lane0      = w_strb_r[0];
    assign wr_bits       = w_data_r[RCT_CAUSE_W-1:0];
    assign wr_status     = wr_fire && wr_lane0 && (aw_addr_r == RCT_ADDR_STATUS);
    assign wr_clear      = wr_fire && wr_lane0 && (aw_addr_r == RCT_ADDR_CLEAR);
    assign wr_irq_clear  = wr_fire && wr_lane0 && (aw_addr_r == RCT_ADDR_IRQ_CLEAR);
    assign wr_irq_enable = wr_fire && wr_lane0 && (aw_addr_r == RCT_ADDR_IRQ_ENABLE);

    // software reset by direct request, or by a clear that keeps the bit set
    always_comb begin
        sw_req = wr_status && wr_bits[RCT_BIT_SW];
        if (wr_clear && status_r[RCT_BIT_SW] && !wr_bits[RCT_BIT_SW]) begin
            sw_req = 1'b1;
        end
    end

    // ==================================================================
    // reset triggers, one per source
    always_comb begin
        trig              = RCT_CAUSE_NONE;
        trig[RCT_BIT_POR] = pin_bus.assert_p[RCT_PIN_POR];
        trig[RCT_BIT_WDT] = wdt_timeout && !wdt_prev_r;
        trig[RCT_BIT_SW]  = sw_req;
        trig[RCT_BIT_EXT] = pin_bus.assert_p[RCT_PIN_EXT];
    end

    // ==================================================================
    // cause register; set beats a clear in the same cycle
    always_comb begin
        status_nxt = status_r;
        if (wr_clear) begin
            status_nxt = status_nxt & ~wr_bits;
        end
        status_nxt = status_nxt | trig;
    end

    // only the block's own reset touches this; internal resets leave it alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= RCT_CAUSE_NONE;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ==================================================================
    // interrupt status, clear and enable
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (wr_irq_clear) begin
            irq_status_nxt = irq_status_nxt & ~wr_bits;
        end
        irq_status_nxt = irq_status_nxt | trig;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= RCT_CAUSE_NONE;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_r <= RCT_CAUSE_NONE;
        end else if (wr_irq_enable) begin
            irq_enable_r <= wr_bits;
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

    // ==================================================================
    // reset sequencer: hold, then hand over to the kernel
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RCT_IDLE: begin
                if (|trig) begin
                    state_nxt = RCT_HOLD;
                end
            end
            RCT_HOLD: begin
                if (!(|trig) && (cnt_r == RCT_CNT_ONE)) begin
                    state_nxt = RCT_BOOT;
                end
            end
            RCT_BOOT: state_nxt = (|trig) ? RCT_HOLD : RCT_IDLE;
            default:  state_nxt = RCT_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= RCT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // a new trigger during the hold restarts the full hold time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= RCT_CNT_ZERO;
        end else if (|trig) begin
            cnt_r <= RCT_HOLD_CYC;
        end else if (cnt_r != RCT_CNT_ZERO) begin
            cnt_r <= cnt_r - RCT_CNT_ONE;
        end
    end

    // power-on kind sticks for the whole hold, even if other sources join in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_kind_r <= 1'b0;
        end else if (trig[RCT_BIT_POR]) begin
            por_kind_r <= 1'b1;
        end else if (state_r == RCT_BOOT) begin
            por_kind_r <= 1'b0;
        end
    end

    // ==================================================================
    // reset effects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_rst_n_r <= 1'b0;
        end else begin
            sys_rst_n_r <= (state_nxt != RCT_HOLD);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_rst_n_r <= 1'b0;
        end else begin
            wdt_rst_n_r <= !((state_nxt == RCT_HOLD) && (por_kind_r || trig[RCT_BIT_POR]));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kernel_start_r <= 1'b0;
        end else begin
            kernel_start_r <= (state_r == RCT_HOLD) && (state_nxt == RCT_BOOT);
        end
    end

    // ram content is lost only at power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_valid_r <= 1'b0;
        end else if (trig[RCT_BIT_POR]) begin
            ram_valid_r <= 1'b0;
        end else if ((state_r == RCT_BOOT) && !por_kind_r) begin
            ram_valid_r <= 1'b1;
        end
    end

    assign sys_rst_n    = sys_rst_n_r;
    assign wdt_rst_n    = wdt_rst_n_r;
    assign kernel_start = kernel_start_r;
    assign ram_valid    = ram_valid_r;

    // ==================================================================
    // axi4-lite write channel; address and data are taken in either order
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready  = !w_hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= RCT_DATA_ZERO;
        end else if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            w_data_r <= RCT_DATA_ZERO;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RCT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= rct_mapped(aw_addr_r) ? RCT_RESP_OKAY : RCT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ==================================================================
    // axi4-lite read channel; write-only registers read as zero
    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= RCT_DATA_ZERO;
            rresp_r  <= RCT_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rct_mapped(s_axi_araddr) ? RCT_RESP_OKAY : RCT_RESP_SLVERR;
            case (s_axi_araddr)
                RCT_ADDR_STATUS:     rdata_r <= rct_word(status_r);
                RCT_ADDR_IRQ_STATUS: rdata_r <= rct_word(irq_status_r);
                RCT_ADDR_IRQ_ENABLE: rdata_r <= rct_word(irq_enable_r);
                default:             rdata_r <= RCT_DATA_ZERO;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

endmodule

// ===== test/rct_checker.sv
// port assertions and cover points for the reset cause tracker
module rct_checker
    import rct_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // read channel
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // reset sources
    input wire logic        por_n,
    input wire logic        ext_rst_n,
    input wire logic        wdt_timeout,
    // reset effects
    input wire logic        sys_rst_n,
    input wire logic        wdt_rst_n,
    input wire logic        kernel_start,
    input wire logic        ram_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // hold length counter, a repetition would be far too long
    logic [7:0] low_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_rst_n) low_cnt_r <= 8'h00;
        else low_cnt_r <= low_cnt_r + 8'h01;
    end

    // ==========================================================
    // assertions
    a_wdt_starts_reset: assert property ($rose(wdt_timeout) |=> !sys_rst_n)
        else $error("watchdog timeout did not start a reset");
    a_ext_starts_reset: assert property ($fell(ext_rst_n) ##1 (!ext_rst_n)[*6] |-> !sys_rst_n)
        else $error("reset pin did not start a reset");
    a_por_resets_wdt: assert property ($fell(por_n) ##1 (!por_n)[*6] |-> !wdt_rst_n)
        else $error("power-on did not reset the watchdog");
    a_wdt_kept_alive: assert property ($rose(wdt_timeout) && wdt_rst_n |=> wdt_rst_n)
        else $error("watchdog reset by a non power-on cause");
    a_hold_length: assert property (kernel_start |-> low_cnt_r == RCT_HOLD_CYC)
        else $error("reset hold length wrong");
    a_boot_pulse: assert property (kernel_start |-> $rose(sys_rst_n) ##1 !kernel_start)
        else $error("kernel start not a single pulse at release");
    a_ram_kept: assert property (kernel_start && $past(wdt_rst_n, 2) |=> ram_valid)
        else $error("ram not valid after a non power-on reset");
    a_ram_lost: assert property (kernel_start && !$past(wdt_rst_n, 2) |=> !ram_valid)
        else $error("ram valid after a power-on reset");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h000_0000)
        else $error("unused bits read as one");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    c_boot: cover property (kernel_start);
    c_por: cover property ($fell(wdt_rst_n));
    c_sw_bit: cover property (s_axi_rvalid && s_axi_rdata[2]);
endmodule

bind rct_top rct_checker u_rct_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .por_n(por_n), .ext_rst_n(ext_rst_n),
    .wdt_timeout(wdt_timeout), .sys_rst_n(sys_rst_n), .wdt_rst_n(wdt_rst_n),
    .kernel_start(kernel_start), .ram_valid(ram_valid)
);

// ===== test/tb_reset_cause_tracker.sv
// self-checking bench for the reset cause tracker
module tb_reset_cause_tracker;
    timeunit 1ns;
    timeprecision 1ps;
    import rct_pkg::*;

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

    // ==========================================================
    // signals
    logic        aclk;
    logic        aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0, wr_strb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        por_n = 1'h1, ext_rst_n = 1'h1, wdt_timeout = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [31:0] s_axi_rdata, rd_data;
    logic        sys_rst_n, wdt_rst_n, kernel_start, ram_valid, irq;
    logic [15:0] lfsr_r = 16'h3AB5;
    int          mismatches = 0, samples_checked = 0, exp_st = 0;

    rct_top uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .por_n(por_n),
        .ext_rst_n(ext_rst_n), .wdt_timeout(wdt_timeout), .sys_rst_n(sys_rst_n),
        .wdt_rst_n(wdt_rst_n), .kernel_start(kernel_start), .ram_valid(ram_valid), .irq(irq)
    );

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= wr_strb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        wr_resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask

    task automatic chk_st();
        rd(RCT_ADDR_STATUS);
        `CHK("status", 32'(exp_st), rd_data)
    endtask

    // one-cycle timeout pulse, returns with the reset under way
    task automatic wdt_pulse();
        @(posedge aclk);
        wdt_timeout <= 1'h1;
        @(posedge aclk);
        wdt_timeout <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic boot(input logic rv);
        int n;
        n = 0;
        while (kernel_start !== 1'h1 && n < 300) begin
            @(posedge aclk);
            n++;
        end
        `CHK("kernel_start", 1'h1, kernel_start)
        @(posedge aclk);
        `CHK("ram_valid", rv, ram_valid)
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        chk_st();
        wdt_pulse();
        `CHK("sys_rst_n", 1'h0, sys_rst_n)
        `CHK("wdt_rst_n", 1'h1, wdt_rst_n)
        exp_st |= 2;
        boot(1'h1);
        chk_st();
        // pin reset on top of an uncleared cause
        ext_rst_n <= 1'h0;
        repeat (8) @(posedge aclk);
        ext_rst_n <= 1'h1;
        exp_st |= 8;
        boot(1'h1);
        chk_st();
        por_n <= 1'h0;
        repeat (8) @(posedge aclk);
        `CHK("wdt_rst_n", 1'h0, wdt_rst_n)
        por_n <= 1'h1;
        exp_st |= 1;
        boot(1'h0);
        chk_st();
        wr(RCT_ADDR_CLEAR, 32'h0000_000F);
        `CHK("bresp", RCT_RESP_OKAY, wr_resp)
        exp_st = 0;
        chk_st();
        // software request, other bits random and ignored
        lfsr_r = lfsr_step(lfsr_r);
        wr(RCT_ADDR_STATUS, {lfsr_r, lfsr_r} | 32'h0000_0004);
        `CHK("sys_rst_n", 1'h0, sys_rst_n)
        exp_st = 4;
        boot(1'h1);
        chk_st();
        wr(RCT_ADDR_CLEAR, {lfsr_r, lfsr_r} & 32'hFFFF_FFFB);
        `CHK("sys_rst_n", 1'h0, sys_rst_n)
        boot(1'h1);
        chk_st();
        wr(RCT_ADDR_CLEAR, 32'h0000_0004);
        `CHK("sys_rst_n", 1'h1, sys_rst_n)
        exp_st = 0;
        chk_st();
        rd(RCT_ADDR_CLEAR);
        `CHK("clear read", 32'h0000_0000, rd_data)
        rd(32'hFFFF_0300);
        `CHK("unmapped rresp", RCT_RESP_SLVERR, rd_resp)
        wr(32'hFFFF_0300, 32'h0000_0004);
        `CHK("unmapped bresp", RCT_RESP_SLVERR, wr_resp)
        `CHK("sys_rst_n", 1'h1, sys_rst_n)
        // status write with byte lane 0 off must not request a reset
        wr_strb = 4'hE;
        wr(RCT_ADDR_STATUS, 32'h0000_0004);
        wr_strb = 4'hF;
        `CHK("lane0 off", 1'h1, sys_rst_n)
        chk_st();
        // interrupt raised, masked, cleared
        wr(RCT_ADDR_IRQ_CLEAR, 32'h0000_000F);
        wr(RCT_ADDR_IRQ_ENABLE, 32'h0000_0002);
        `CHK("irq idle", 1'h0, irq)
        wdt_pulse();
        `CHK("irq", 1'h1, irq)
        exp_st = 2;
        boot(1'h1);
        rd(RCT_ADDR_IRQ_STATUS);
        `CHK("irq status", 32'h0000_0002, rd_data)
        wr(RCT_ADDR_IRQ_ENABLE, 32'h0000_0000);
        `CHK("irq masked", 1'h0, irq)
        wr(RCT_ADDR_IRQ_ENABLE, 32'h0000_0002);
        `CHK("irq unmasked", 1'h1, irq)
        wr(RCT_ADDR_IRQ_CLEAR, 32'h0000_0002);
        `CHK("irq cleared", 1'h0, irq)
        chk_st();
        end_of_test();
    end

    // hang guard, about six times the expected run
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
endmodule
